// File: dtodc_regs.svh
// constants for the disciplined time-of-day counter
// assumes: included by bare name from every design file that needs them
`ifndef DTODC_REGS_SVH
`define DTODC_REGS_SVH

// ------------------------------------------------------------
// widths and section count
// ------------------------------------------------------------
`define DTODC_DAC_W        10
`define DTODC_SEC_W        16
`define DTODC_NSEC         3
`define DTODC_DIV_W        16
`define DTODC_SYNC_N       5

// ------------------------------------------------------------
// swallow stage moduli
// ------------------------------------------------------------
`define DTODC_MOD_W        4
`define DTODC_DIV_NORMAL   4'ha
`define DTODC_DIV_SWALLOW  4'hb

// ------------------------------------------------------------
// synchroniser bit positions
// ------------------------------------------------------------
`define DTODC_SY_READ      0
`define DTODC_SY_ACK       1
`define DTODC_SY_DAC       2
`define DTODC_SY_DIV       3
`define DTODC_SY_FIXED     4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define DTODC_RST_DAC      10'h200
`define DTODC_RST_DIV      16'h0000

`endif

// File: dtodc_pkg.sv
// types shared by the disciplined time-of-day counter files
// assumes: nothing beyond the tool's package support
package dtodc_pkg;

    // ------------------------------------------------------------
    // swallow stage modes
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        DTODC_ST_NORMAL  = 2'b01,
        DTODC_ST_SWALLOW = 2'b10
    } dtodc_mode_e;

endpackage

// File: dtodc_counter.sv
// one loadable up-counter section with carry out
// assumes: inc and load come from logic on clk
`timescale 1ns/100ps
`include "dtodc_regs.svh"

module dtodc_counter #(
    parameter int W = `DTODC_SEC_W
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    // control
    input  wire logic         inc,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    // result
    output logic      [W-1:0] count,
    output logic              carry
);
    import dtodc_pkg::*;

    // carry only while a counted pulse leaves the top value
    assign carry = inc & (&count);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else if (load) begin
            count <= load_val;
        end else if (inc) begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
        end
    end

endmodule

// File: dtodc_swallow.sv
// dual-modulus swallow prescaler, divide by ten or eleven
// assumes: swallow_req is a one-cycle pulse on clk
`timescale 1ns/100ps
`include "dtodc_regs.svh"

module dtodc_swallow (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rstn,
    // control
    input  wire logic                      swallow_req,
    // result
    output logic                           out_pulse,
    output dtodc_pkg::dtodc_mode_e         mode
);
    import dtodc_pkg::*;

    logic [`DTODC_MOD_W-1:0] cnt;
    logic [`DTODC_MOD_W-1:0] modulus;
    logic                    pending;
    logic                    wrap;

    assign modulus = (mode == DTODC_ST_SWALLOW) ? `DTODC_DIV_SWALLOW : `DTODC_DIV_NORMAL;
    assign wrap    = (cnt == modulus - 4'h1);

    // ------------------------------------------------------------
    // division counter
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt       <= 4'h0;
            out_pulse <= 1'b0;
        end else begin
            out_pulse <= wrap;
            cnt       <= wrap ? 4'h0 : cnt + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // request held until the next division cycle starts
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pending <= 1'b0;
        end else if (wrap) begin
            pending <= 1'b0; // a request on the wrap goes straight to mode
        end else if (swallow_req) begin
            pending <= 1'b1;
        end
    end

    // one division cycle by eleven, then back to ten unless another request is pending or arrives on the wrap
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mode <= DTODC_ST_NORMAL;
        end else if (wrap) begin
            case (mode)
                DTODC_ST_NORMAL: begin
                    mode <= (pending | swallow_req) ? DTODC_ST_SWALLOW : DTODC_ST_NORMAL;
                end
                DTODC_ST_SWALLOW: begin
                    mode <= (pending | swallow_req) ? DTODC_ST_SWALLOW : DTODC_ST_NORMAL;
                end
                default: begin
                    mode <= DTODC_ST_NORMAL;
                end
            endcase
        end
    end

endmodule

// File: dtodc_top.sv
// disciplined time-of-day counter: prescaler, cascaded time counter,
// tick latch, read latch, converter latch and pulse-rate divider
// assumes: host strobes arrive unsynchronised; data words stay stable
// from before a load strobe rises until after it falls
//
// Overview of operation
// - counter overflow sets the tick latch, which drives the interrupt output.
// - tick latch clears only on a processor acknowledge.
// - frequency-control converter word is at least ten bits wide.
// - read pulse copies the counter into a holding latch for the host.
// - converter correction word is held until the host rewrites it.
// - fixed-oscillator prescaler divides by ten, by eleven when commanded.
// - host-loaded divider emits one control pulse at each overflow.
// - each divider pulse makes one divide-by-eleven cycle, swallowing one pulse.
// - higher divider rate swallows more, lowering counted frequency.
// - 48-bit counter of three 16-bit sections, plus swallow and divider.
`timescale 1ns/100ps
`include "dtodc_regs.svh"

module dtodc_top #(
    parameter int DAC_W = `DTODC_DAC_W,
    parameter int SEC_W = `DTODC_SEC_W,
    parameter int NSEC  = `DTODC_NSEC,
    parameter int DIV_W = `DTODC_DIV_W
) (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rstn,
    // host strobes
    input  wire logic                   read_strobe,
    input  wire logic                   tick_ack,
    input  wire logic                   dac_load,
    input  wire logic                   div_load,
    input  wire logic                   fixed_osc,
    // host data
    input  wire logic [DAC_W-1:0]       dac_data,
    input  wire logic [DIV_W-1:0]       div_data,
    // interrupt and status
    output logic                        tick_irq,
    output logic                        tick_overrun,
    output logic                        latch_valid,
    // captured time
    output logic [NSEC*SEC_W-1:0]       time_latch,
    // oscillator steering
    output logic [DAC_W-1:0]            dac_word,
    output logic                        dac_update,
    // prescaler observation
    output logic                        prescaler_pulse,
    output logic                        divider_pulse,
    output logic                        swallow_mode
);
    import dtodc_pkg::*;

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [`DTODC_SYNC_N-1:0]     sync_a;
    logic [`DTODC_SYNC_N-1:0]     sync_b;
    logic [`DTODC_SYNC_N-1:0]     sync_c;
    logic [`DTODC_SYNC_N-1:0]     stable;
    logic [`DTODC_SYNC_N-1:0]     stable_d;
    logic [`DTODC_SYNC_N-1:0]     rise;
    logic [`DTODC_SYNC_N-1:0]     next_stable;

    logic                         read_evt;
    logic                         ack_evt;
    logic                         dac_evt;
    logic                         div_evt;
    logic                         swallow_en;

    logic [DAC_W-1:0]             dac_a;
    logic [DAC_W-1:0]             dac_b;
    logic [DAC_W-1:0]             dac_c;
    logic [DAC_W-1:0]             dac_held;
    logic [DIV_W-1:0]             div_a;
    logic [DIV_W-1:0]             div_b;
    logic [DIV_W-1:0]             div_c;
    logic [DIV_W-1:0]             div_held;

    logic [DIV_W-1:0]             div_value;
    logic                         div_carry;
    logic [DIV_W-1:0]             div_count;
    logic                         swallow_req;

    logic                         pre_pulse;
    dtodc_mode_e                  mode;

    logic [NSEC:0]                sec_inc;
    logic [NSEC-1:0][SEC_W-1:0]   sec_count;
    logic                         tick_evt;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_a <= '0;
            sync_b <= '0;
            sync_c <= '0;
        end else begin
            sync_a <= {fixed_osc, div_load, dac_load, tick_ack, read_strobe};
            sync_b <= sync_a;
            sync_c <= sync_b;
        end
    end

    // a change counts once the second and third stages agree
    always_comb begin
        next_stable = stable;
        for (int i = 0; i < `DTODC_SYNC_N; i++) begin
            if (sync_b[i] == sync_c[i]) begin
                next_stable[i] = sync_c[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stable   <= '0;
            stable_d <= '0;
        end else begin
            stable   <= next_stable;
            stable_d <= stable;
        end
    end

    assign rise       = stable & ~stable_d;
    assign read_evt   = rise[`DTODC_SY_READ];
    assign ack_evt    = rise[`DTODC_SY_ACK];
    assign dac_evt    = rise[`DTODC_SY_DAC];
    assign div_evt    = rise[`DTODC_SY_DIV];
    assign swallow_en = stable[`DTODC_SY_FIXED];

    // ------------------------------------------------------------
    // host data synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_a <= '0;
            dac_b <= '0;
            dac_c <= '0;
            div_a <= '0;
            div_b <= '0;
            div_c <= '0;
        end else begin
            dac_a <= dac_data;
            dac_b <= dac_a;
            dac_c <= dac_b;
            div_a <= div_data;
            div_b <= div_a;
            div_c <= div_b;
        end
    end

    // same depth as the strobe path, so a load sees the settled word
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_held <= '0;
            div_held <= '0;
        end else begin
            if (dac_b == dac_c) begin
                dac_held <= dac_c;
            end
            if (div_b == div_c) begin
                div_held <= div_c;
            end
        end
    end

    // ------------------------------------------------------------
    // converter latch for the oscillator
    // ------------------------------------------------------------
    // width defaults to ten bits; do not shrink below that
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dac_word   <= DAC_W'(`DTODC_RST_DAC);
            dac_update <= 1'b0;
        end else begin
            dac_update <= dac_evt;
            if (dac_evt) begin
                dac_word <= dac_held;
            end
        end
    end

    // ------------------------------------------------------------
    // pulse-rate divider
    // ------------------------------------------------------------
    // larger load value means a shorter period and a higher rate
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            div_value <= DIV_W'(`DTODC_RST_DIV);
        end else if (div_evt) begin
            div_value <= div_held;
        end
    end

    dtodc_counter #(
        .W        (DIV_W)
    ) u_pulse_rate_divider (
        .clk      (clk),
        .rstn     (rstn),
        .inc      (1'b1),
        .load     (div_carry | div_evt),
        .load_val (div_evt ? div_held : div_value),
        .count    (div_count),
        .carry    (div_carry)
    );

    // one pulse per overflow, only in the fixed-oscillator variant
    assign swallow_req = div_carry & swallow_en;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            divider_pulse <= 1'b0;
        end else begin
            divider_pulse <= swallow_req;
        end
    end

    // ------------------------------------------------------------
    // swallow prescaler
    // ------------------------------------------------------------
    // each request lengthens one output period by one clock
    dtodc_swallow u_swallow (
        .clk         (clk),
        .rstn        (rstn),
        .swallow_req (swallow_req),
        .out_pulse   (pre_pulse),
        .mode        (mode)
    );

    // more requests per second, fewer counted pulses per second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prescaler_pulse <= 1'b0;
            swallow_mode    <= 1'b0;
        end else begin
            prescaler_pulse <= pre_pulse;
            swallow_mode    <= (mode == DTODC_ST_SWALLOW);
        end
    end

    // ------------------------------------------------------------
    // cascaded time counter
    // ------------------------------------------------------------
    assign sec_inc[0] = pre_pulse;

    for (genvar k = 0; k < NSEC; k++) begin : g_sec
        dtodc_counter #(
            .W        (SEC_W)
        ) u_sec (
            .clk      (clk),
            .rstn     (rstn),
            .inc      (sec_inc[k]),
            .load     (1'b0),
            .load_val ({SEC_W{1'b0}}),
            .count    (sec_count[k]),
            .carry    (sec_inc[k+1])
        );
    end

    // lowest section overflow is the hardware tick
    assign tick_evt = sec_inc[1];

    // ------------------------------------------------------------
    // tick latch
    // ------------------------------------------------------------
    // an overflow in the acknowledge cycle keeps the latch set
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_irq <= 1'b0;
        end else if (tick_evt) begin
            tick_irq <= 1'b1;
        end else if (ack_evt) begin
            tick_irq <= 1'b0;
        end
    end

    // a tick that lands on an unacknowledged one is flagged
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tick_overrun <= 1'b0;
        end else if (tick_evt & tick_irq & ~ack_evt) begin
            tick_overrun <= 1'b1;
        end else if (ack_evt) begin
            tick_overrun <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // read latch
    // ------------------------------------------------------------
    // all sections captured in one edge, so no torn carry
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            time_latch  <= '0;
            latch_valid <= 1'b0;
        end else begin
            if (read_evt) begin
                time_latch  <= sec_count;
                latch_valid <= 1'b1;
            end
        end
    end

endmodule

// File: dtodc_props.sv
// assertions on the ports of the time-of-day counter top
// assumes: bound to dtodc_top from the testbench top file
`timescale 1ns/100ps

module dtodc_props #(
    parameter int DAC_W = 10,
    parameter int SEC_W = 16,
    parameter int NSEC  = 3
) (
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire logic                  read_strobe,
    input wire logic                  tick_ack,
    input wire logic                  dac_load,
    input wire logic                  fixed_osc,
    input wire logic                  tick_irq,
    input wire logic                  latch_valid,
    input wire logic [NSEC*SEC_W-1:0] time_latch,
    input wire logic [DAC_W-1:0]      dac_word,
    input wire logic                  dac_update,
    input wire logic                  prescaler_pulse,
    input wire logic                  divider_pulse
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // ------------------------------------------------------------
    // helper counters
    // ------------------------------------------------------------
    logic [7:0] gap;
    logic       seen;
    logic [4:0] fx_low, ack_age, dac_age, rd_age;

    // cycles since hit, saturating
    function automatic logic [4:0] age(input logic hit, input logic [4:0] a);
        return hit ? 5'h00 : ((a == 5'h1f) ? a : a + 5'h01);
    endfunction

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            gap <= 8'h00;
            seen <= 1'b0;
        end else if (prescaler_pulse) begin
            gap <= 8'h01;
            seen <= 1'b1;
        end else if (gap != 8'hff) begin
            gap <= gap + 8'h01;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            fx_low <= 5'h1f;
            ack_age <= 5'h1f;
            dac_age <= 5'h1f;
            rd_age <= 5'h1f;
        end else begin
            fx_low <= age(fixed_osc, fx_low);
            ack_age <= age(tick_ack, ack_age);
            dac_age <= age(dac_load, dac_age);
            rd_age <= age(read_strobe, rd_age);
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_period_range: assert property (prescaler_pulse && seen |-> gap == 8'h0a || gap == 8'h0b)
        else $error("prescaler period outside ten or eleven");
    a_pulse_single: assert property (prescaler_pulse |=> !prescaler_pulse [*8])
        else $error("prescaler pulse repeated too soon");
    a_vco_period: assert property (prescaler_pulse && seen && fx_low == 5'h1f |-> gap == 8'h0a)
        else $error("swallow seen with fixed oscillator off");
    a_div_gated: assert property (divider_pulse |-> fx_low < 5'h08)
        else $error("divider pulse without fixed oscillator");
    a_irq_cause: assert property ($rose(tick_irq) |-> prescaler_pulse)
        else $error("tick raised without a prescaler pulse");
    a_irq_clear: assert property ($fell(tick_irq) |-> ack_age < 5'h0a)
        else $error("tick cleared without acknowledge");
    a_dac_change: assert property ($changed(dac_word) |-> dac_update)
        else $error("converter word changed without update");
    a_dac_cause: assert property (dac_update |-> dac_age < 5'h0a && !$past(dac_update))
        else $error("converter update without load");
    a_latch_cause: assert property ($changed(time_latch) || $rose(latch_valid) |-> rd_age < 5'h0a)
        else $error("time latch changed without read");

    c_tick: cover property ($rose(tick_irq));
    c_swallow: cover property (prescaler_pulse && seen && gap == 8'h0b);
    c_dac: cover property (dac_update);
endmodule

// File: dtodc_host.sv
// host processor model: strobe sequencing and software clock
// assumes: go bits are one-cycle pulses driven after the rising edge
`timescale 1ns/100ps

module dtodc_host #(
    parameter logic [31:0] INCR = 32'h0000_0010
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rstn,
    // bench requests
    input  wire logic [3:0]  go,
    input  wire logic        auto_ack,
    input  wire logic        tick_irq,
    // strobes to the device and software time
    output logic      [3:0]  strobe,
    output logic      [31:0] sw_time
);
    logic [2:0] hold [4];
    logic       ack_go;

    assign ack_go = go[1] | (auto_ack & tick_irq);

    // ------------------------------------------------------------
    // strobe high 4 cycles, low at least 4; adjust by loads only
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold <= '{default: 3'h0};
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (hold[i] != 3'h0) begin
                    hold[i] <= hold[i] + 3'h1;
                end else if ((i == 1) ? ack_go : go[i]) begin
                    hold[i] <= 3'h1;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            strobe[i] = (hold[i] != 3'h0) && (hold[i] < 3'h5);
        end
    end

    // unsigned increment on each acknowledge keeps time monotonic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sw_time <= 32'h0;
        end else if (hold[1] == 3'h0 && ack_go) begin
            sw_time <= sw_time + INCR;
        end
    end
endmodule

// File: dtodc_tb.sv
// self-checking bench for the time-of-day counter
// assumes: host model in dtodc_host.sv, checker in dtodc_props.sv
`timescale 1ns/100ps

module dtodc_tb;
    localparam int SEC_W = 4;
    localparam int TW    = 3 * SEC_W;

    logic          clk, rstn, fixed_osc, auto_ack;
    logic [3:0]    go, strobe;
    logic [9:0]    dac_data, dac_word;
    logic [15:0]   div_data;
    logic [TW-1:0] time_latch, a;
    logic [31:0]   sw_time, s;
    logic          tick_irq, latch_valid, dac_update, prescaler_pulse, divider_pulse;
    logic          tick_overrun, swallow_mode;
    int            error_cnt, check_count, n, pn, fp, fd, sp, sd, m0, mf, ms;

    dtodc_top #(.SEC_W(SEC_W)) uut (
        .clk(clk), .rstn(rstn), .read_strobe(strobe[0]), .tick_ack(strobe[1]),
        .dac_load(strobe[2]), .div_load(strobe[3]), .fixed_osc(fixed_osc),
        .dac_data(dac_data), .div_data(div_data), .tick_irq(tick_irq),
        .tick_overrun(tick_overrun), .latch_valid(latch_valid), .time_latch(time_latch),
        .dac_word(dac_word), .dac_update(dac_update), .prescaler_pulse(prescaler_pulse),
        .divider_pulse(divider_pulse), .swallow_mode(swallow_mode)
    );

    dtodc_host u_host (
        .clk(clk), .rstn(rstn), .go(go), .auto_ack(auto_ack), .tick_irq(tick_irq),
        .strobe(strobe), .sw_time(sw_time)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic wait_for(input string what, ref logic sig, input int lim);
        n = 0;
        while (sig !== 1'b1) begin
            step(1);
            n++;
            if (n > lim) begin
                error_cnt++;
                $display("unexpected timeout on %s: expected 1, seen 0", what);
                tally_and_finish();
            end
        end
    endtask

    task automatic req(input int i);
        go[i] = 1'b1;
        step(1);
        go[i] = 1'b0;
    endtask

    task automatic count(input int k, output int pp, output int dp, output int mp);
        pp = 0;
        dp = 0;
        mp = 0;
        repeat (k) begin
            step(1);
            pp += int'(prescaler_pulse);
            dp += int'(divider_pulse);
            mp += int'(swallow_mode);
        end
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check("dac_word", 32'h200, 32'(dac_word));
        check("tick_irq", 32'h0, 32'(tick_irq));
        check("latch_valid", 32'h0, 32'(latch_valid));
        check("converter width ok", 32'h1, 32'($bits(uut.dac_word) >= 10));
        $display("test reset done");
    endtask

    task automatic t_read();
        wait_for("prescaler_pulse", prescaler_pulse, 30);
        step(1);
        pn = 1;
        while (prescaler_pulse !== 1'b1 && pn < 30) begin
            step(1);
            pn++;
        end
        check("prescaler period", 32'd10, 32'(pn));
        req(0);
        step(12);
        a = time_latch;
        step(87);
        req(0);
        step(12);
        check("time delta", 32'd10, 32'(TW'(time_latch - a)));
        check("latch_valid", 32'h1, 32'(latch_valid));
        $display("test read done");
    endtask

    task automatic t_dac();
        dac_data = 10'h3a5;
        req(2);
        wait_for("dac_update", dac_update, 20);
        check("dac_word", 32'h3a5, 32'(dac_word));
        dac_data = 10'h05a;
        step(50);
        check("dac_word held", 32'h3a5, 32'(dac_word));
        $display("test dac done");
    endtask

    task automatic t_tick();
        wait_for("tick_irq", tick_irq, 400);
        step(30);
        check("tick held", 32'h1, 32'(tick_irq));
        req(1);
        step(12);
        check("tick cleared", 32'h0, 32'(tick_irq));
        s = sw_time;
        auto_ack = 1'b1;
        step(400);
        auto_ack = 1'b0;
        check("software clock advanced", 32'h1, 32'((sw_time - s) >= 32'h20));
        step(330);
        check("tick overrun", 32'h1, 32'(tick_overrun));
        req(1);
        step(12);
        check("overrun cleared", 32'h0, 32'({tick_irq, tick_overrun}));
        $display("test tick done");
    endtask

    task automatic t_swallow();
        count(2200, pn, n, m0);
        check("plain pulse count", 32'd220, 32'(pn));
        check("plain swallow cycles", 32'd0, 32'(m0));
        fixed_osc = 1'b1;
        div_data = 16'hfff5;
        req(3);
        step(40);
        count(2200, fp, fd, mf);
        check("fast swallow cycles", 32'd2200, 32'(mf));
        check("fast count in range", 32'h1, 32'(fp >= 199 && fp <= 201));
        check("divider pulses", 32'h1, 32'(fd >= 199 && fd <= 201));
        div_data = 16'hff38;
        req(3);
        step(40);
        count(2200, sp, sd, ms);
        check("one period per pulse", 32'h1, 32'(ms >= 99 && ms <= 143));
        check("slow above fast", 32'h1, 32'(sp > fp && sp <= 220 && sd < fd));
        fixed_osc = 1'b0;
        $display("test swallow done");
    endtask

    initial begin
        rstn = 1'b0;
        fixed_osc = 1'b0;
        auto_ack = 1'b0;
        go = 4'h0;
        dac_data = 10'h000;
        div_data = 16'h0000;
        error_cnt = 0;
        check_count = 0;
        repeat (12) @(posedge clk);
        #1;
        rstn = 1'b1;
        t_reset();
        t_read();
        t_dac();
        t_tick();
        t_swallow();
        tally_and_finish();
    end
endmodule

bind dtodc_top dtodc_props #(.DAC_W(DAC_W), .SEC_W(SEC_W), .NSEC(NSEC)) u_props (
    .clk, .rstn, .read_strobe, .tick_ack, .dac_load, .fixed_osc, .tick_irq, .latch_valid,
    .time_latch, .dac_word, .dac_update, .prescaler_pulse, .divider_pulse
);
